// >>> src/tccp_pkg.sv
// Purpose: constants for the paired timer with capture, compare and pulse output
// Assumes: 32-bit apb, one aligned word per register
// Notes: register offsets are byte addresses
package tccp_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] OFF_TIMER0_MODE = 8'h00;
  localparam logic [7:0] OFF_TIMER1_MODE = 8'h04;
  localparam logic [7:0] OFF_TIMER0_DATA = 8'h08;
  localparam logic [7:0] OFF_TIMER1_DATA = 8'h0C;
  localparam logic [7:0] OFF_PERIOD_LOW = 8'h10;
  localparam logic [7:0] OFF_DUTY_LOW = 8'h14;
  localparam logic [7:0] OFF_HIGH_BITS = 8'h18;
  localparam logic [7:0] OFF_PORT_FUNC = 8'h1C;
  localparam logic [7:0] OFF_EDGE_SEL = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int T0_CAP_BIT = 4;   // capture_enable_t0 in timer0 mode
  localparam int T0_RUN_BIT = 0;   // counter run in both mode regs
  localparam int T1_CHAIN_BIT = 7; // chain_enable in timer1 mode
  localparam int T1_CAP_BIT = 6;   // capture_enable_t1
  localparam int T1_PULSE_MODE_ENABLE_BIT = 5;  // pulse_mode_enable
  localparam int T1_POL_BIT = 4;   // duty_active_sense
  localparam int PF_PIN_BIT = 0;   // compare_pin_function / pulse_pin_function
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_MATCH = 8'hFF;
  // edge select codes per pin
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
endpackage

// >>> src/tccp_timer.sv
// Purpose: paired 8-bit timers with capture, compare toggle and 10-bit pulse output
// Assumes: apb slave with zero wait states, pins are asynchronous
// Notes: prescaler is a plain divider selected by clock-select bits
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
module tccp_timer
  import tccp_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_trigger_pin0_in,
  input wire logic capture_trigger_pin1_in,
  input wire logic ext_count_in,
  output logic timer0_irq_out,
  output logic timer1_irq_out,
  output logic capture0_irq_out,
  output logic capture1_irq_out,
  output logic out_pin_out
);
  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] timer0_mode_reg, timer1_mode_reg;
  logic [7:0] timer0_match_value, timer1_match_value;
  logic [7:0] timer0_captured_value, timer1_captured_value;
  logic [7:0] timer0_count, timer1_count;
  logic [7:0] pulse_period_low, pulse_duty_low;
  logic [3:0] pulse_high_bits_reg;
  logic [9:0] duty_active;
  logic [9:0] pulse_count;
  logic [3:0] edge_select_reg;
  logic port_b_function_reg;
  logic [3:0] irq_flags;
  logic compare_level, pulse_level;
  logic [2:0] pin0_sync, pin1_sync, ext_sync;
  logic [10:0] pre_cnt;
  logic [10:0] pre_cnt_prev;

  // decode of the operating mode
  logic chain_enable, capture_enable_t0, capture_enable_t1, pulse_mode_enable;
  logic duty_active_sense, run0, run1;
  assign chain_enable = timer1_mode_reg[T1_CHAIN_BIT];
  assign capture_enable_t0 = timer0_mode_reg[T0_CAP_BIT];
  assign capture_enable_t1 = timer1_mode_reg[T1_CAP_BIT] & ~chain_enable;
  assign pulse_mode_enable = timer1_mode_reg[T1_PULSE_MODE_ENABLE_BIT] & ~chain_enable
    & ~timer1_mode_reg[T1_CAP_BIT];
  assign duty_active_sense = timer1_mode_reg[T1_POL_BIT];
  assign run0 = timer0_mode_reg[T0_RUN_BIT];
  assign run1 = timer1_mode_reg[T0_RUN_BIT];

  // ************************************************************
  // pin synchronisers and edge detect
  // ************************************************************
  // third stage only feeds the edge compare, keeping stage one private
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      pin0_sync <= 3'h0;
      pin1_sync <= 3'h0;
      ext_sync <= 3'h0;
    end else begin
      pin0_sync <= {pin0_sync[1:0], capture_trigger_pin0_in};
      pin1_sync <= {pin1_sync[1:0], capture_trigger_pin1_in};
      ext_sync <= {ext_sync[1:0], ext_count_in};
    end
  end

  function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic was);
    case (sel)
      EDGE_FALL: edge_hit = was & ~now;
      EDGE_RISE: edge_hit = ~was & now;
      default: edge_hit = was ^ now;
    endcase
  endfunction

  logic capture_enable_t0_evt, capture_enable_t1_evt;
  assign capture_enable_t0_evt = capture_enable_t0
    & edge_hit(edge_select_reg[1:0], pin0_sync[1], pin0_sync[2]);
  assign capture_enable_t1_evt = capture_enable_t1
    & edge_hit(edge_select_reg[3:2], pin1_sync[1], pin1_sync[2]);

  // ************************************************************
  // prescaler and count ticks
  // ************************************************************
  // free-running divider; a tap rising gives one tick per ratio
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      pre_cnt <= 11'h000;
      pre_cnt_prev <= 11'h000;
    end else begin
      pre_cnt <= pre_cnt + 11'h001;
      pre_cnt_prev <= pre_cnt;
    end
  end

  function automatic logic tap(input logic [10:0] cur, input logic [10:0] prv, input int b);
    tap = cur[b] & ~prv[b];
  endfunction

  logic tick0, tick1_own, tick1;
  always_comb begin
    case (timer0_mode_reg[3:1])
      3'h0: tick0 = tap(pre_cnt, pre_cnt_prev, 0);
      3'h1: tick0 = tap(pre_cnt, pre_cnt_prev, 1);
      3'h2: tick0 = tap(pre_cnt, pre_cnt_prev, 2);
      3'h3: tick0 = tap(pre_cnt, pre_cnt_prev, 4);
      3'h4: tick0 = tap(pre_cnt, pre_cnt_prev, 6);
      3'h5: tick0 = tap(pre_cnt, pre_cnt_prev, 8);
      3'h6: tick0 = tap(pre_cnt, pre_cnt_prev, 10);
      default: tick0 = ext_sync[1] & ~ext_sync[2]; // external rising edge
    endcase
  end
  always_comb begin
    case (timer1_mode_reg[2:1])
      2'h0: tick1_own = 1'b1;
      2'h1: tick1_own = tap(pre_cnt, pre_cnt_prev, 0);
      2'h2: tick1_own = tap(pre_cnt, pre_cnt_prev, 2);
      default: tick1_own = 1'b0; // chained: fed from timer 0 carry
    endcase
  end

  // ************************************************************
  // counters
  // ************************************************************
  logic [15:0] wide_count, wide_match;
  logic match0, match1, match16;
  assign wide_count = {timer1_count, timer0_count};
  assign wide_match = {timer1_match_value, timer0_match_value};
  assign match16 = chain_enable & (wide_count == wide_match);
  assign match0 = chain_enable ? match16 : (timer0_count == timer0_match_value);
  assign match1 = ~chain_enable & (timer1_count == timer1_match_value);
  assign tick1 = chain_enable ? (tick0 & run0 & timer0_count == 8'hFF) : (tick1_own & run1);
  logic [9:0] period_full;
  logic period_hit;
  assign period_full = {pulse_high_bits_reg[3:2], pulse_period_low};
  // last count of the period, so one period lasts exactly period_full ticks
  assign period_hit = ({1'b0, pulse_count} + 11'h001) >= {1'b0, period_full};

  // timer 0 runs alone or as the low byte of the chain
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      timer0_count <= RST_BYTE;
      timer0_captured_value <= RST_BYTE;
    end else if (capture_enable_t0_evt) begin
      timer0_captured_value <= timer0_count;
      timer0_count <= RST_BYTE;
    end else if (tick0 & run0) begin
      timer0_count <= match0 ? RST_BYTE : timer0_count + 8'h01;
    end
  end

  // timer 1 counts as a timer, or drives the pulse counter in pulse mode
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      timer1_count <= RST_BYTE;
      timer1_captured_value <= RST_BYTE;
    end else if (capture_enable_t0_evt & chain_enable) begin
      timer1_captured_value <= timer1_count;
      timer1_count <= RST_BYTE;
    end else if (capture_enable_t1_evt) begin
      timer1_captured_value <= timer1_count;
      timer1_count <= RST_BYTE;
    end else if (tick1 & ~pulse_mode_enable) begin
      timer1_count <= (chain_enable ? (match16) : match1) ? RST_BYTE : timer1_count + 8'h01;
    end
  end

  // ************************************************************
  // pulse generator
  // ************************************************************
  // duty master moves to the active copy only at period end or while pulse mode is off, so no glitch
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      pulse_count <= 10'h000;
      duty_active <= 10'h000;
    end else if (~pulse_mode_enable) begin
      pulse_count <= 10'h000;
      duty_active <= {pulse_high_bits_reg[1:0], pulse_duty_low};
    end else if (tick1_own & run1) begin
      if (period_hit) begin
        pulse_count <= 10'h000;
        duty_active <= {pulse_high_bits_reg[1:0], pulse_duty_low};
      end else begin
        pulse_count <= pulse_count + 10'h001;
      end
    end
  end

  // output level: active before duty count, inactive after
  logic next_pulse_level;
  always_comb begin
    if (duty_active == 10'h000) begin
      next_pulse_level = ~duty_active_sense;
    end else if (duty_active >= period_full) begin
      next_pulse_level = duty_active_sense;
    end else if (pulse_count < duty_active) begin
      next_pulse_level = duty_active_sense;
    end else begin
      next_pulse_level = ~duty_active_sense;
    end
  end

  // compare toggles once per match (chained: only when the low match byte is FF) so two matches make one period
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      compare_level <= 1'b0;
      pulse_level <= 1'b0;
    end else begin
      pulse_level <= next_pulse_level;
      if (~pulse_mode_enable & tick1 & (chain_enable ? match16 : match1)) begin
        compare_level <= ~compare_level;
      end
    end
  end

  // pin shows pulse or compare only when its function bit is set
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      out_pin_out <= 1'b0;
    end else if (~port_b_function_reg) begin
      out_pin_out <= 1'b0;
    end else begin
      out_pin_out <= pulse_mode_enable ? pulse_level : compare_level;
    end
  end

  // ************************************************************
  // interrupt event flags
  // ************************************************************
  // flags are sticky; a set in the cycle of a clear wins
  logic [3:0] evt, clr;
  assign evt = {capture_enable_t1_evt, capture_enable_t0_evt,
    ~pulse_mode_enable & tick1 & match1,
    tick0 & run0 & match0};
  assign clr = (psel & penable & pwrite & paddr[7:0] == OFF_STATUS) ? pwdata[3:0] : 4'h0;
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      irq_flags <= 4'h0;
    end else begin
      irq_flags <= (irq_flags & ~clr) | evt;
    end
  end
  assign timer0_irq_out = irq_flags[0];
  assign timer1_irq_out = irq_flags[1];
  assign capture0_irq_out = irq_flags[2];
  assign capture1_irq_out = irq_flags[3];

  // ************************************************************
  // apb slave
  // ************************************************************
  logic wr_en;
  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // one process for all software-written registers except the status flags, which are cleared in the flag process
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      timer0_mode_reg <= RST_BYTE;
      timer1_mode_reg <= RST_BYTE;
      timer0_match_value <= RST_MATCH;
      timer1_match_value <= RST_MATCH;
      pulse_period_low <= RST_BYTE;
      pulse_duty_low <= RST_BYTE;
      pulse_high_bits_reg <= 4'h0;
      port_b_function_reg <= 1'b0;
      edge_select_reg <= 4'h0;
    end else if (wr_en) begin
      case (paddr[7:0])
        OFF_TIMER0_MODE: timer0_mode_reg <= pwdata[7:0];
        OFF_TIMER1_MODE: timer1_mode_reg <= pwdata[7:0];
        OFF_TIMER0_DATA: timer0_match_value <= pwdata[7:0];
        OFF_TIMER1_DATA: timer1_match_value <= pwdata[7:0];
        OFF_PERIOD_LOW: pulse_period_low <= pwdata[7:0];
        OFF_DUTY_LOW: pulse_duty_low <= pwdata[7:0];
        OFF_HIGH_BITS: pulse_high_bits_reg <= pwdata[3:0];
        OFF_PORT_FUNC: port_b_function_reg <= pwdata[PF_PIN_BIT];
        OFF_EDGE_SEL: edge_select_reg <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // read mux registered so data come from flops; valid at the access phase
  logic [7:0] rd_byte;
  logic cap_view0, cap_view1;
  assign cap_view0 = capture_enable_t0;
  assign cap_view1 = capture_enable_t1 | (chain_enable & capture_enable_t0);
  always_comb begin
    case (paddr[7:0])
      OFF_TIMER0_MODE: rd_byte = timer0_mode_reg;
      OFF_TIMER1_MODE: rd_byte = timer1_mode_reg;
      OFF_TIMER0_DATA: rd_byte = cap_view0 ? timer0_captured_value : timer0_count;
      OFF_TIMER1_DATA: rd_byte = cap_view1 ? timer1_captured_value : timer1_count;
      OFF_PERIOD_LOW: rd_byte = pulse_period_low;
      OFF_DUTY_LOW: rd_byte = pulse_duty_low;
      OFF_HIGH_BITS: rd_byte = {4'h0, pulse_high_bits_reg};
      OFF_PORT_FUNC: rd_byte = {7'h00, port_b_function_reg};
      OFF_EDGE_SEL: rd_byte = {4'h0, edge_select_reg};
      OFF_STATUS: rd_byte = {4'h0, irq_flags};
      default: rd_byte = 8'h00;
    endcase
  end
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end
endmodule

// >>> verif/tccp_timer_sva.sv
// Purpose: checker on the timer ports
// Assumes: apb writes are shadowed here
// Notes: constant pwm levels judged once config has been quiet
`timescale 1ns/1ns
module tccp_timer_sva
  import tccp_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic capture_trigger_pin1_in,
  input wire logic timer1_irq_out,
  input wire logic capture1_irq_out,
  input wire logic out_pin_out
);
  logic [7:0] mode1, per_lo, dut_lo, quiet;
  logic [3:0] hb, es;
  logic pin_fn;
  wire wr = psel && penable && pwrite;
  wire clr = wr && (paddr[7:0] == OFF_STATUS);
  wire [9:0] per = {hb[3:2], per_lo};
  wire [9:0] dut = {hb[1:0], dut_lo};
  wire pwm_on = mode1[5] && !mode1[6] && !mode1[7] && mode1[0] && pin_fn
    && (quiet == 8'hFF) && (per <= 10'h064);
  // shadow of the registers the rules depend on
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      {mode1, per_lo, dut_lo, hb, es, pin_fn} <= '0;
    end else if (wr) begin
      case (paddr[7:0])
        OFF_TIMER1_MODE: mode1 <= pwdata[7:0];
        OFF_PERIOD_LOW: per_lo <= pwdata[7:0];
        OFF_DUTY_LOW: dut_lo <= pwdata[7:0];
        OFF_HIGH_BITS: hb <= pwdata[3:0];
        OFF_EDGE_SEL: es <= pwdata[3:0];
        OFF_PORT_FUNC: pin_fn <= pwdata[0];
        default: ;
      endcase
    end
  end
  // cycles since last write; long enough for the duty copy to settle
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || wr) begin
      quiet <= 8'h00;
    end else if (quiet != 8'hFF) begin
      quiet <= quiet + 8'h01;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  a_pin_off_low: assert property (
    !pin_fn [*3] |-> !out_pin_out) else $error("pin driven while function off");
  a_t1irq_sticky: assert property (
    timer1_irq_out && !(clr && pwdata[1]) |=> timer1_irq_out) else $error("timer1 flag lost");
  a_capirq_sticky: assert property (
    capture1_irq_out && !(clr && pwdata[3]) |=> capture1_irq_out) else $error("capture flag lost");
  a_capture_flag_rise: assert property (
    mode1[6] && !mode1[7] && es[3:2] == EDGE_RISE && $rose(capture_trigger_pin1_in)
    |-> ##[1:6] capture1_irq_out)
    else $error("capture edge raised no flag");
  a_capture_off_quiet: assert property (
    !mode1[6] && !capture1_irq_out |=> !capture1_irq_out) else $error("capture flag while off");
  a_full_duty_level: assert property (
    pwm_on && dut == per |-> out_pin_out == mode1[4]) else $error("full duty level wrong");
  a_zero_duty_level: assert property (
    pwm_on && dut == 10'h000 && per != 10'h000 |-> out_pin_out == !mode1[4])
    else $error("zero duty level wrong");
  a_upper_read_zero: assert property (
    $past(psel) |-> prdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  c_pwm_edge: cover property (pwm_on && $rose(out_pin_out));
  c_capture: cover property ($rose(capture1_irq_out));
  c_match: cover property ($rose(timer1_irq_out));
endmodule
bind tccp_timer tccp_timer_sva u_sva (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .capture_trigger_pin1_in(capture_trigger_pin1_in),
  .timer1_irq_out(timer1_irq_out), .capture1_irq_out(capture1_irq_out),
  .out_pin_out(out_pin_out));

// >>> verif/tccp_far_side.sv
// Purpose: pulse source on the capture pins and load on the output pin
// Assumes: pins change just after a rising edge
// Notes: external count input is held low, timer0 counts internally
`timescale 1ns/1ns
module tccp_far_side (
  input wire logic clk_in,
  input wire logic pin_level_in,
  output logic trig0_out,
  output logic trig1_out,
  output logic ext_count_out
);
  // quiet pins from time zero
  initial begin
    trig0_out = 1'b0;
    trig1_out = 1'b0;
    ext_count_out = 1'b0;
  end
  // two rising edges exactly gap cycles apart on pin 0 or pin 1
  task automatic pulse_pair(input int gap, input bit on_pin0);
    repeat (2) begin
      @(posedge clk_in);
      trig0_out <= on_pin0;
      trig1_out <= !on_pin0;
      repeat (gap / 2) @(posedge clk_in);
      trig0_out <= 1'b0;
      trig1_out <= 1'b0;
      repeat (gap - gap / 2 - 1) @(posedge clk_in);
    end
  endtask
  // count high cycles of the load pin over a window
  task automatic measure(input int n, output int highs);
    highs = 0;
    repeat (n) begin
      // falling edge: the registered pin has settled by then
      @(negedge clk_in);
      if (pin_level_in === 1'b1) highs++;
    end
  endtask
endmodule

// >>> verif/timer_capture_compare_pwm_bench.sv
// Purpose: self-checking bench for the timer block
// Assumes: zero wait apb slave, timer1 source is every clock except in the chained test
// Notes: windows of 100 cycles span whole periods, so counts are phase free
`timescale 1ns/1ns
module timer_capture_compare_pwm_bench import tccp_pkg::*;;
  logic sys_clk_in, srst_in, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic trig0, trig1, ext_cnt, t0_irq, t1_irq, c0_irq, c1_irq, pin;
  int miscompares = 0;
  int checks_done = 0;
  tccp_timer DUT (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_trigger_pin0_in(trig0),
    .capture_trigger_pin1_in(trig1), .ext_count_in(ext_cnt), .timer0_irq_out(t0_irq),
    .timer1_irq_out(t1_irq), .capture0_irq_out(c0_irq), .capture1_irq_out(c1_irq),
    .out_pin_out(pin));
  tccp_far_side far (.clk_in(sys_clk_in), .pin_level_in(pin), .trig0_out(trig0),
    .trig1_out(trig1), .ext_count_out(ext_cnt));
  // 25 MHz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge sys_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h00_0000, a};
    pwdata <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      wrap_up();
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0000_0000, q);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_reset_reads();
    logic [7:0] addr_tab [4] = '{OFF_TIMER0_MODE, OFF_TIMER1_DATA, OFF_STATUS, 8'h30};
    logic [31:0] q;
    foreach (addr_tab[i]) begin
      rd(addr_tab[i], q);
      check(q, 32'h0000_0000);
    end
    check({31'h0, pslverr}, 32'h0000_0000);
  endtask
  // timer1 match 4 toggles the pin every 5 clocks
  task automatic test_compare();
    int highs;
    wr(OFF_PORT_FUNC, 32'h0000_0001);
    wr(OFF_TIMER1_DATA, 32'h0000_0004);
    wr(OFF_STATUS, 32'h0000_000F);
    wr(OFF_TIMER1_MODE, 32'h0000_0001);
    repeat (20) @(posedge sys_clk_in);
    far.measure(100, highs);
    check(32'(highs), 32'h0000_0032);
    check({31'h0, t1_irq}, 32'h0000_0001);
    check({31'h0, t0_irq}, 32'h0000_0000);
  endtask
  // period 10, duty and polarity from the table
  task automatic test_pwm();
    logic [7:0] duty_tab [4] = '{8'h03, 8'h03, 8'h0A, 8'h00};
    logic [31:0] pol_tab [4] = '{32'h0000_0010, 32'h0000_0000, 32'h0000_0010, 32'h0000_0010};
    logic [31:0] high_tab [4] = '{32'h0000_001E, 32'h0000_0046, 32'h0000_0064, 32'h0000_0000};
    int highs;
    foreach (duty_tab[i]) begin
      wr(OFF_TIMER1_MODE, 32'h0000_0000);
      wr(OFF_PERIOD_LOW, 32'h0000_000A);
      wr(OFF_DUTY_LOW, {24'h00_0000, duty_tab[i]});
      wr(OFF_HIGH_BITS, 32'h0000_0000);
      wr(OFF_TIMER1_MODE, 32'h0000_0021 | pol_tab[i]);
      repeat (260) @(posedge sys_clk_in);
      far.measure(100, highs);
      check(32'(highs), high_tab[i]);
    end
  endtask
  // two rising edges 40 clocks apart capture 39, then match still counts
  task automatic test_capture();
    logic [31:0] q;
    wr(OFF_TIMER1_MODE, 32'h0000_0000);
    wr(OFF_PORT_FUNC, 32'h0000_0000);
    wr(OFF_EDGE_SEL, 32'h0000_0004);
    wr(OFF_TIMER1_DATA, 32'h0000_00FF);
    wr(OFF_STATUS, 32'h0000_000F);
    wr(OFF_TIMER1_MODE, 32'h0000_0041);
    far.pulse_pair(40, 1'b0);
    repeat (10) @(posedge sys_clk_in);
    check({31'h0, c1_irq}, 32'h0000_0001);
    wr(OFF_TIMER1_DATA, 32'h0000_0010);
    wr(OFF_STATUS, 32'h0000_000F);
    repeat (300) @(posedge sys_clk_in);
    check({31'h0, t1_irq}, 32'h0000_0001);
    rd(OFF_TIMER1_DATA, q);
    check(q, 32'h0000_0027);
  endtask
  // chained timers tick every second clock; odd gap 601 keeps 300 ticks phase free
  task automatic test_chain_capture();
    logic [31:0] q;
    wr(OFF_TIMER1_MODE, 32'h0000_0087);
    wr(OFF_EDGE_SEL, 32'h0000_0001);
    wr(OFF_STATUS, 32'h0000_000F);
    wr(OFF_TIMER0_MODE, 32'h0000_0011);
    far.pulse_pair(601, 1'b1);
    repeat (10) @(posedge sys_clk_in);
    check({31'h0, c0_irq}, 32'h0000_0001);
    rd(OFF_TIMER0_DATA, q);
    check(q, 32'h0000_002C);
    rd(OFF_TIMER1_DATA, q);
    check(q, 32'h0000_0001);
  endtask
  // main sequence
  initial begin
    srst_in = 1'b1;
    {psel, penable, pwrite} = 3'b000;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    test_reset_reads();
    test_compare();
    test_pwm();
    test_capture();
    test_chain_capture();
    wrap_up();
  end
endmodule
